/* verilog/lch_pkg.sv */
`default_nettype none
package lch_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] LED9_CURRENT_LEVEL_OFS        = 8'h2B;
  localparam logic [7:0] DOUBLE_PULSE_ENABLE_SELECT_OFS = 8'h2C;
  localparam logic [7:0] LED6_EVEN_PULSE_CURRENT_OFS   = 8'h2D;

  localparam int CODE_MSB    = 6;
  localparam int CODE_W      = 7;
  localparam int DP_CH_N     = 4;
  localparam int DP_CH9_BIT  = 3;
  localparam int DP_CH8_BIT  = 2;
  localparam int DP_CH7_BIT  = 1;
  localparam int DP_CH6_BIT  = 0;

  localparam logic [6:0] LED9_CURRENT_RST  = 7'h00;
  localparam logic [3:0] DP_ENABLE_RST     = 4'h0;
  localparam logic [6:0] LED6_EVEN_RST     = 7'h00;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // ----------------------------------------
  // full-scale selection, in quarter-milliamp units
  // ----------------------------------------
  localparam logic [5:0] FS_SEL_25MA   = 6'h02;
  localparam logic [5:0] FS_SEL_12MA5  = 6'h0C;
  localparam logic [5:0] FS_SEL_8MA25  = 6'h16;
  localparam logic [5:0] FS_SEL_6MA25  = 6'h20;
  localparam logic [5:0] FS_SEL_5MA    = 6'h2A;
  localparam logic [6:0] FS_Q_25MA     = 7'h64;
  localparam logic [6:0] FS_Q_12MA5    = 7'h32;
  localparam logic [6:0] FS_Q_8MA25    = 7'h21;
  localparam logic [6:0] FS_Q_6MA25    = 7'h19;
  localparam logic [6:0] FS_Q_5MA      = 7'h14;
  localparam logic [6:0] FS_Q_NONE     = 7'h00;
  localparam int         DRIVE_W       = 21;

  // ----------------------------------------
  // serial bus engine
  // ----------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV  = 3'b001,
    ST_PTR  = 3'b010,
    ST_WR   = 3'b011,
    ST_RD   = 3'b100
  } lch_state_t;

endpackage
`default_nettype wire

/* verilog/lch_regs.sv */
// Operation
// RULE1: channel-9 current register at 0x2B, code in bits 6:0, bit 7 reserved.
// RULE2: every channel code is scaled by the global full-scale selection field.
// RULE3: selections 02,0C,16,20,2A give 25,12.5,8.25,6.25,5 mA full scale.
// RULE4: code 00 gives zero, 7F full scale, nonlinear in between.
// RULE5: double-pulse enable register at 0x2C, bits 3:0 used, 7:4 reserved.
// RULE6: enable bit 3 belongs to channel 9.
// RULE7: enable bit 2 belongs to channel 8.
// RULE8: enable bit 1 belongs to channel 7.
// RULE9: enable bit 0 belongs to channel 6.
// RULE10: enabled channel uses its double-pulse settings on every even pulse.
// RULE11: disabled channel ignores double-pulse settings, normal settings only.
// RULE12: channel-6 even-pulse current register sits at 0x2D.
// RULE13: even-pulse current register holds a 7-bit code in bits 6:0.
// RULE14: reserved bits read zero and ignore writes.
`default_nettype none
module lch_regs
  import lch_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h35, // arbitrary bus address
  parameter int         CH_N     = 4
)
(
  input  wire logic                          ref_clk,
  input  wire logic                          arst_n,
  input  wire logic                          sclIn,
  input  wire logic                          sdaIn,
  output var  logic                          sdaOut,
  output var  logic                          sdaOeN,
  input  wire logic [5:0]                    levelSet,
  input  wire logic [lch_pkg::DP_CH_N-1:0]   evenPulse,
  input  wire logic [lch_pkg::CODE_MSB:0]    led6NormalCode,
  input  wire logic [lch_pkg::CODE_MSB:0]    led9EvenCode,
  output var  logic [lch_pkg::DRIVE_W-1:0]   ch9Drive,
  output var  logic [lch_pkg::DRIVE_W-1:0]   ch6Drive,
  output var  logic [lch_pkg::DP_CH_N-1:0]   doublePulseApply,
  output var  logic [lch_pkg::DP_CH_N-1:0]   doublePulseOn
);
  import lch_pkg::*;

  if (CH_N != DP_CH_N)
  begin : g_bad_ch
    $error("lch_regs: only four double-pulse channels are supported");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic sclS1;
  logic sclS2;
  logic sclS3;
  logic sdaS1;
  logic sdaS2;
  logic sdaS3;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {sclS1, sclS2, sclS3} <= 3'h7;
      {sdaS1, sdaS2, sdaS3} <= 3'h7;
    end
    else
    begin
      {sclS1, sclS2, sclS3} <= {sclIn, sclS1, sclS2};
      {sdaS1, sdaS2, sdaS3} <= {sdaIn, sdaS1, sdaS2};
    end
  end

  wire sclRise = sclS2 & ~sclS3;
  wire sclFall = ~sclS2 & sclS3;
  // start and stop only count while the clock line is steady high
  wire busStart = sclS2 & sclS3 & ~sdaS2 & sdaS3;
  wire busStop  = sclS2 & sclS3 & sdaS2 & ~sdaS3;

  // ----------------------------------------
  // registers and read decode
  // ----------------------------------------
  logic [CODE_MSB:0]  led9CurrentCode;
  logic [DP_CH_N-1:0] doublePulseEnable;
  logic [CODE_MSB:0]  led6EvenCode;
  logic [7:0]         ptr;

  function automatic logic [7:0] read_of(input logic [7:0] a,
                                         input logic [6:0] c9,
                                         input logic [3:0] en,
                                         input logic [6:0] c6);
    read_of = (a == LED9_CURRENT_LEVEL_OFS)        ? {1'b0, c9} :       // RULE1 RULE14
              (a == DOUBLE_PULSE_ENABLE_SELECT_OFS) ? {4'h0, en} :       // RULE5 RULE14
              (a == LED6_EVEN_PULSE_CURRENT_OFS)    ? {1'b0, c6} :       // RULE12 RULE14
              UNMAPPED_READ;
  endfunction

  wire [7:0] ptrNext   = ptr + 8'h01;
  wire [7:0] rdNow     = read_of(ptr, led9CurrentCode, doublePulseEnable, led6EvenCode);
  wire [7:0] rdNext    = read_of(ptrNext, led9CurrentCode, doublePulseEnable, led6EvenCode);

  // ----------------------------------------
  // serial bus engine
  // ----------------------------------------
  lch_state_t state;
  logic [7:0] sh;
  logic [3:0] bitCnt;
  logic       ackPhase;

  wire byteDone  = sclFall & ~ackPhase & (bitCnt == BITS_PER_BYTE);
  wire addrHit   = (sh[7:1] == DEV_ADDR);
  wire wrStrobe  = byteDone & (state == ST_WR);
  wire wrLed9    = wrStrobe & (ptr == LED9_CURRENT_LEVEL_OFS);
  wire wrDp      = wrStrobe & (ptr == DOUBLE_PULSE_ENABLE_SELECT_OFS);
  wire wrLed6E   = wrStrobe & (ptr == LED6_EVEN_PULSE_CURRENT_OFS);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state    <= ST_IDLE;
      sh       <= 8'h00;
      bitCnt   <= 4'h0;
      ackPhase <= 1'b0;
      ptr      <= 8'h00;
      sdaOeN   <= 1'b1;
    end
    else if (busStart)
    begin
      state    <= ST_DEV;
      bitCnt   <= 4'h0;
      ackPhase <= 1'b0;
      sdaOeN   <= 1'b1;
    end
    else if (busStop)
    begin
      state    <= ST_IDLE;
      ackPhase <= 1'b0;
      sdaOeN   <= 1'b1;
    end
    else if (state != ST_IDLE)
    begin
      if (sclRise)
      begin
        if (!ackPhase)
        begin
          sh     <= {sh[6:0], sdaS2};
          bitCnt <= bitCnt + 4'h1;
        end
        else if (state == ST_RD && sdaOeN)
        begin
          // the ack after the read address is ours; only the master's ack slot
          // may move the pointer, else the first byte would come from ptr+1
          // master nack ends the read burst
          if (sdaS2)
            state <= ST_IDLE;
          else
          begin
            sh  <= rdNext;
            ptr <= ptrNext;
          end
        end
      end
      else if (sclFall)
      begin
        if (ackPhase)
        begin
          ackPhase <= 1'b0;
          bitCnt   <= 4'h0;
          sdaOeN   <= (state == ST_RD) ? sh[7] : 1'b1;
        end
        else if (bitCnt == BITS_PER_BYTE)
        begin
          ackPhase <= 1'b1;
          case (state)
            ST_DEV:
            begin
              if (addrHit)
              begin
                sdaOeN <= 1'b0;
                state  <= sh[0] ? ST_RD : ST_PTR;
                sh     <= rdNow;
              end
              else
                state <= ST_IDLE;
            end
            ST_PTR:
            begin
              ptr    <= sh;
              sdaOeN <= 1'b0;
              state  <= ST_WR;
            end
            ST_WR:
            begin
              // pointer auto-increments for burst writes
              ptr    <= ptrNext;
              sdaOeN <= 1'b0;
            end
            default:
              sdaOeN <= 1'b1;
          endcase
        end
        else if (state == ST_RD)
          sdaOeN <= sh[7];
      end
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      led9CurrentCode   <= LED9_CURRENT_RST;
      doublePulseEnable <= DP_ENABLE_RST;
      led6EvenCode      <= LED6_EVEN_RST;
      sdaOut            <= 1'b0;
    end
    else
    begin
      if (wrLed9)
        led9CurrentCode <= sh[CODE_MSB:0];              // RULE1 RULE14
      if (wrDp)
        doublePulseEnable <= sh[DP_CH_N-1:0];           // RULE5 RULE14
      if (wrLed6E)
        led6EvenCode <= sh[CODE_MSB:0];                 // RULE12 RULE13 RULE14
      sdaOut <= 1'b0;
    end
  end

  // ----------------------------------------
  // current scaling
  // ----------------------------------------
  // square law matches the low end of the schedule: 1,4,9 over 16129
  wire [6:0] fullScale =
    (levelSet == FS_SEL_25MA)  ? FS_Q_25MA  :           // RULE3
    (levelSet == FS_SEL_12MA5) ? FS_Q_12MA5 :
    (levelSet == FS_SEL_8MA25) ? FS_Q_8MA25 :
    (levelSet == FS_SEL_6MA25) ? FS_Q_6MA25 :
    (levelSet == FS_SEL_5MA)   ? FS_Q_5MA   :
    FS_Q_NONE;

  logic [DP_CH_N-1:0] next_apply;
  genvar gi;
  for (gi = 0; gi < DP_CH_N; gi++)
  begin : g_dp
    // disabled channel never sees its even-pulse settings
    assign next_apply[gi] = doublePulseEnable[gi] & evenPulse[gi];   // RULE10 RULE11
  end

  wire [6:0] ch9Code = next_apply[DP_CH9_BIT] ? led9EvenCode : led9CurrentCode; // RULE6
  wire [6:0] ch6Code = next_apply[DP_CH6_BIT] ? led6EvenCode : led6NormalCode;  // RULE9

  wire [13:0] ch9Sq = 14'(ch9Code) * 14'(ch9Code);       // RULE4
  wire [13:0] ch6Sq = 14'(ch6Code) * 14'(ch6Code);       // RULE4
  wire [DRIVE_W-1:0] next_ch9Drive = DRIVE_W'(fullScale) * DRIVE_W'(ch9Sq); // RULE2
  wire [DRIVE_W-1:0] next_ch6Drive = DRIVE_W'(fullScale) * DRIVE_W'(ch6Sq); // RULE2

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ch9Drive         <= '0;
      ch6Drive         <= '0;
      doublePulseApply <= '0;
      doublePulseOn    <= '0;
    end
    else
    begin
      ch9Drive         <= next_ch9Drive;
      ch6Drive         <= next_ch6Drive;
      doublePulseApply <= next_apply;                    // RULE7 RULE8
      doublePulseOn    <= doublePulseEnable;
    end
  end

endmodule
`default_nettype wire

/* tb/lch_chk.sv */
`default_nettype none
module lch_chk
(
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        sclIn,
  input wire logic        sdaOut,
  input wire logic        sdaOeN,
  input wire logic [5:0]  levelSet,
  input wire logic [3:0]  evenPulse,
  input wire logic [20:0] ch9Drive,
  input wire logic [20:0] ch6Drive,
  input wire logic [3:0]  doublePulseApply,
  input wire logic [3:0]  doublePulseOn
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  dp9_apply_a: assert property (doublePulseApply[3] == (doublePulseOn[3] & $past(evenPulse[3])))
    else $error("ch9 apply");
  dp8_apply_a: assert property (doublePulseApply[2] == (doublePulseOn[2] & $past(evenPulse[2])))
    else $error("ch8 apply");
  dp7_apply_a: assert property ($past(evenPulse[1]) |-> doublePulseApply[1] == doublePulseOn[1])
    else $error("ch7 apply");
  dp6_apply_a: assert property (!$past(evenPulse[0]) |-> !doublePulseApply[0])
    else $error("ch6 apply");
  fs_none_a: assert property ($past(levelSet) == 6'h00 |-> ch9Drive == 21'h0 && ch6Drive == 21'h0)
    else $error("drive without scale");
  sda_move_a: assert property (sdaOeN != $past(sdaOeN) |-> !sclIn)
    else $error("sda moved with scl high");
  ack_len_a: assert property ($fell(sdaOeN) |-> ##[1:400] $rose(sdaOeN))
    else $error("sda held too long");
  sda_low_a: assert property (sdaOut == 1'b0) else $error("sda data high");
endmodule
`default_nettype wire

/* tb/lch_host.sv */
`default_nettype none
module lch_host
(
  input  wire logic ref_clk,
  input  wire logic sdaWire,
  output var  logic scl = 1'b1,
  output var  logic sdaOeN = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // one frame: b before scl rise, b2 after; b!=b2 makes a start or stop
  task automatic bitIo(input logic b, input logic b2, output logic q);
    sdaOeN = b;
    repeat (10) @(negedge ref_clk);
    scl = 1'b1;
    repeat (8) @(negedge ref_clk);
    q = sdaWire;
    sdaOeN = b2;
    repeat (8) @(negedge ref_clk);
    scl = b2 & ~b;
  endtask
  task automatic byteIo(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
      bitIo(d[i], d[i], q[i]);
  endtask
  // read sends ones so the pull-up lets the device's bits through
  task automatic xfer(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
                      input logic rdn, output logic [7:0] q, output logic a);
    logic [8:0] r0, r1, r2, r3;
    logic       s;
    bitIo(1'b1, 1'b0, s);
    byteIo({dev, 2'b01}, r0);
    byteIo({p, 1'b1}, r1);
    if (rdn)
      bitIo(1'b1, 1'b0, s);
    if (rdn)
      byteIo({dev, 2'b11}, r2);
    byteIo(rdn ? 9'h1FF : {d, 1'b1}, r3);
    bitIo(1'b0, 1'b1, s);
    q = r3[8:1];
    a = r0[0] | r1[0] | (r2[0] & rdn) | (r3[0] & ~rdn);
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, arst_n = 1'b0;
  logic [5:0]  levelSet = 6'h00;
  logic [3:0]  evenPulse = 4'h0, doublePulseApply, doublePulseOn;
  logic        scl, hostOeN, sdaOut, sdaOeN, a;
  logic [7:0]  q;
  logic [20:0] ch9Drive, ch6Drive;
  wire logic   sdaWire = (sdaOeN | sdaOut) & hostOeN;
  int          mismatches = 0, comparisons = 0;
  lch_regs i_dut
  (
    .ref_clk          (ref_clk),
    .arst_n           (arst_n),
    .sclIn            (scl),
    .sdaIn            (sdaWire),
    .sdaOut           (sdaOut),
    .sdaOeN           (sdaOeN),
    .levelSet         (levelSet),
    .evenPulse        (evenPulse),
    .led6NormalCode   (7'h10),
    .led9EvenCode     (7'h20),
    .ch9Drive         (ch9Drive),
    .ch6Drive         (ch6Drive),
    .doublePulseApply (doublePulseApply),
    .doublePulseOn    (doublePulseOn)
  );
  lch_host i_host (.ref_clk, .sdaWire, .scl, .sdaOeN(hostOeN));
  initial
    forever #20 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    mismatches += int'(got !== exp);
    if (got !== exp)
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic acc(input logic [7:0] p, input logic [7:0] d, input logic rdn,
                     input logic [7:0] e);
    i_host.xfer(7'h35, p, d, rdn, q, a);
    chk({23'h0, a, q}, {24'h0, e});
  endtask
  task automatic test_regs;
    logic [7:0] ofs [4] = '{8'h2B, 8'h2C, 8'h2D, 8'h2E};
    logic [7:0] msk [4] = '{8'h7F, 8'h0F, 8'h7F, 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      acc(ofs[i], 8'h00, 1'b1, 8'h00);
      acc(ofs[i], 8'hFF, 1'b0, 8'hFF);
      acc(ofs[i], 8'h00, 1'b1, msk[i]);
    end
    i_host.xfer(7'h36, 8'h2B, 8'h00, 1'b0, q, a);
    chk({31'h0, a}, 32'h1);
    $display("register map test done");
  endtask
  task automatic test_scale;
    logic [5:0] sel [5] = '{6'h02, 6'h0C, 6'h16, 6'h20, 6'h2A};
    logic [6:0] fq [5] = '{7'h64, 7'h32, 7'h21, 7'h19, 7'h14};
    for (int i = 0; i < 5; i++)
    begin
      levelSet = sel[i];
      repeat (3) @(negedge ref_clk);
      chk(32'(ch9Drive), fq[i] * 32'h3F01);
    end
    $display("full scale test done");
  endtask
  // scale stays at 5 mA full scale here, so expected drives use 20 quarter-mA
  task automatic test_dp;
    logic [3:0] ens [2] = '{4'h6, 4'h9};
    // channels 7 and 8 first, then 6 and 9, which stay on for the drive checks
    for (int k = 0; k < 2; k++)
    begin
      acc(8'h2C, 8'(ens[k]), 1'b0, 8'(ens[k]));
      chk(32'(doublePulseOn), 32'(ens[k]));
      for (int i = 0; i < 4; i++)
      begin
        evenPulse = 4'(1 << i);
        repeat (3) @(negedge ref_clk);
        chk(32'(doublePulseApply), 32'(evenPulse & ens[k]));
      end
    end
    evenPulse = 4'hF;
    repeat (3) @(negedge ref_clk);
    chk(32'(ch9Drive), 32'h5000);
    chk(32'(ch6Drive), 32'h4EC14);
    acc(8'h2C, 8'h00, 1'b0, 8'h00);
    chk(32'(doublePulseOn), 32'h0);
    chk(32'(ch9Drive), 32'h4EC14);
    chk(32'(ch6Drive), 32'h1400);
    $display("double pulse test done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #240 arst_n = 1'b1;
    #160 test_regs;
    test_scale;
    test_dp;
    stop_test;
  end
  initial
  begin
    #3000000 mismatches++;
    stop_test;
  end
endmodule
bind lch_regs lch_chk i_chk
(
  .ref_clk          (ref_clk),
  .arst_n           (arst_n),
  .sclIn            (sclIn),
  .sdaOut           (sdaOut),
  .sdaOeN           (sdaOeN),
  .levelSet         (levelSet),
  .evenPulse        (evenPulse),
  .ch9Drive         (ch9Drive),
  .ch6Drive         (ch6Drive),
  .doublePulseApply (doublePulseApply),
  .doublePulseOn    (doublePulseOn)
);
`default_nettype wire
